// ===== include/ecp_pkg.sv
// Package for the extended card properties register image
// Overview of operation
// - The image is 512 bytes, addressed by byte index 0 to 511.
// - The top 320 byte positions (192 to 511) form the read-only properties segment.
// - Host writes never change a properties byte; it keeps its factory value.
// - The lowest 192 byte positions (0 to 191) form the modes segment that selects the running configuration.
// - Outside reset, modes change only via Switch, which updates only byte 191, the command set byte; set, clear and write to other modes bytes are refused.
// - Byte 224, the large erase unit size, reads as zero.
// - Byte 222, the atomic write sector count, reads as one sector.
// - Byte 221, the large protect unit size, reads as zero.
// - Power-class bytes 200 to 203 read as zero.
// - Minimum rate bytes 205 to 210 read as 8.
// - Every reserved byte reads as zero.
package ecp_pkg;
	localparam int        ECP_IMAGE_BYTES   = 512;
	localparam int        ECP_MODES_BYTES   = 192;
	localparam logic [8:0] ECP_LAST_INDEX   = 9'h1ff;

	// Byte offsets
	localparam logic [8:0] OFS_CMD_SET_SEL  = 9'h0bf;
	localparam logic [8:0] OFS_EXT_REV      = 9'h0c0;
	localparam logic [8:0] OFS_STRUCT_VER   = 9'h0c2;
	localparam logic [8:0] OFS_SPEED_TYPES  = 9'h0c4;
	localparam logic [8:0] OFS_PWR_52_LV    = 9'h0c8;
	localparam logic [8:0] OFS_PWR_26_LV    = 9'h0c9;
	localparam logic [8:0] OFS_PWR_52_HV    = 9'h0ca;
	localparam logic [8:0] OFS_PWR_26_HV    = 9'h0cb;
	localparam logic [8:0] OFS_MIN_R_426    = 9'h0cd;
	localparam logic [8:0] OFS_MIN_W_426    = 9'h0ce;
	localparam logic [8:0] OFS_MIN_R_826    = 9'h0cf;
	localparam logic [8:0] OFS_MIN_W_826    = 9'h0d0;
	localparam logic [8:0] OFS_MIN_R_852    = 9'h0d1;
	localparam logic [8:0] OFS_MIN_W_852    = 9'h0d2;
	localparam logic [8:0] OFS_SECTORS_LO   = 9'h0d4;
	localparam logic [8:0] OFS_SECTORS_HI   = 9'h0d7;
	localparam logic [8:0] OFS_SLEEP_TIME   = 9'h0d9;
	localparam logic [8:0] OFS_SLEEP_IO_I   = 9'h0db;
	localparam logic [8:0] OFS_SLEEP_CORE_I = 9'h0dc;
	localparam logic [8:0] OFS_PROTECT_UNIT = 9'h0dd;
	localparam logic [8:0] OFS_ATOMIC_WR    = 9'h0de;
	localparam logic [8:0] OFS_ERASE_FACTOR = 9'h0df;
	localparam logic [8:0] OFS_ERASE_UNIT   = 9'h0e0;
	localparam logic [8:0] OFS_ACCESS_GRAN  = 9'h0e1;
	localparam logic [8:0] OFS_BOOT_SIZE    = 9'h0e2;
	localparam logic [8:0] OFS_BOOT_CAPABILITY_INFO    = 9'h0e4;
	localparam logic [8:0] OFS_CMD_SETS     = 9'h1f8;

	// Factory values
	localparam logic [7:0] RST_CMD_SET_SEL  = 8'h00;
	localparam logic [7:0] VAL_EXT_REV      = 8'h02;
	localparam logic [7:0] VAL_STRUCT_VER   = 8'h02;
	localparam logic [7:0] VAL_SPEED_TYPES  = 8'h03;
	localparam logic [7:0] VAL_PWR_CLASS    = 8'h00;
	localparam logic [7:0] VAL_MIN_RATE     = 8'h08;
	localparam logic [7:0] VAL_PROTECT_UNIT = 8'h00;
	localparam logic [7:0] VAL_ATOMIC_WR    = 8'h01;
	localparam logic [7:0] VAL_ERASE_FACTOR = 8'h00;
	localparam logic [7:0] VAL_ERASE_UNIT   = 8'h00;
	localparam logic [7:0] VAL_ACCESS_GRAN  = 8'h00;
	localparam logic [7:0] VAL_BOOT_CAPABILITY_INFO    = 8'h01;
	localparam logic [7:0] VAL_CMD_SETS     = 8'h00;
	localparam logic [7:0] VAL_RESERVED     = 8'h00;

	// Switch access modes (command set change, set bits, clear bits, write byte)
	typedef enum logic [1:0] {
		SW_CMD_SET = 2'b00,
		SW_SET_BITS = 2'b01,
		SW_CLR_BITS = 2'b10,
		SW_WRITE   = 2'b11
	} ecp_access_t;

	typedef struct packed {
		logic        valid;
		ecp_access_t access;
		logic [8:0]  index;
		logic [7:0]  value;
	} ecp_switch_t;

	typedef struct packed {
		logic       valid;
		logic [8:0] index;
	} ecp_read_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ecp_rdata_t;
endpackage

// ===== verilog/ecp_regs.sv
// Extended card properties register image with Switch-command update port
`timescale 1ns/1ns
module ecp_regs
	import ecp_pkg::*;
#(
	parameter logic [31:0] SECTOR_COUNT    = 32'h00000000,
	parameter logic [7:0]  SLEEP_TIME      = 8'h00,
	parameter logic [7:0]  SLEEP_IO_I      = 8'h00,
	parameter logic [7:0]  SLEEP_CORE_I    = 8'h00,
	parameter logic [7:0]  BOOT_SIZE_MULT  = 8'h02
) (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire ecp_pkg::ecp_switch_t sw,
	output      logic                sw_done,
	output      logic                sw_error,
	input  wire ecp_pkg::ecp_read_t  rd,
	output      ecp_pkg::ecp_rdata_t rdata,
	output      logic [7:0]          cmd_set_select
);
	import ecp_pkg::*;

	typedef struct packed {
		logic [7:0] cmd_set;
		logic       done;
		logic       error;
		ecp_rdata_t rdata;
	} ecp_state_t;

	ecp_state_t s_q;
	ecp_state_t s_d;

	// Properties and reserved bytes are fixed; only the writable mode byte is stored
	function automatic logic [7:0] image_byte(input logic [8:0] idx, input logic [7:0] cmd_set);
		logic [7:0] b;
		b = VAL_RESERVED;
		case (idx)
			OFS_CMD_SET_SEL:  b = cmd_set;
			OFS_EXT_REV:      b = VAL_EXT_REV;
			OFS_STRUCT_VER:   b = VAL_STRUCT_VER;
			OFS_SPEED_TYPES:  b = VAL_SPEED_TYPES;
			OFS_PWR_52_LV,
			OFS_PWR_26_LV,
			OFS_PWR_52_HV,
			OFS_PWR_26_HV:    b = VAL_PWR_CLASS;
			OFS_MIN_R_426,
			OFS_MIN_W_426,
			OFS_MIN_R_826,
			OFS_MIN_W_826,
			OFS_MIN_R_852,
			OFS_MIN_W_852:    b = VAL_MIN_RATE;
			OFS_SLEEP_TIME:   b = SLEEP_TIME;
			OFS_SLEEP_IO_I:   b = SLEEP_IO_I;
			OFS_SLEEP_CORE_I: b = SLEEP_CORE_I;
			OFS_PROTECT_UNIT: b = VAL_PROTECT_UNIT;
			OFS_ATOMIC_WR:    b = VAL_ATOMIC_WR;
			OFS_ERASE_FACTOR: b = VAL_ERASE_FACTOR;
			OFS_ERASE_UNIT:   b = VAL_ERASE_UNIT;
			OFS_ACCESS_GRAN:  b = VAL_ACCESS_GRAN;
			OFS_BOOT_SIZE:    b = BOOT_SIZE_MULT;
			OFS_BOOT_CAPABILITY_INFO:    b = VAL_BOOT_CAPABILITY_INFO;
			OFS_CMD_SETS:     b = VAL_CMD_SETS;
			default: begin
				if (idx >= OFS_SECTORS_LO && idx <= OFS_SECTORS_HI) begin
					b = SECTOR_COUNT[(idx - OFS_SECTORS_LO) * 8 +: 8];
				end
			end
		endcase
		return b;
	endfunction

	always_comb begin
		s_d       = s_q;
		s_d.done  = 1'b0;
		s_d.error = 1'b0;
		s_d.rdata = '{valid: 1'b0, data: VAL_RESERVED};
		if (sw.valid) begin
			s_d.done = 1'b1;
			// Only the stored mode byte accepts set, clear and write; a command set change is taken at any index; everything else is refused
			if (sw.index == OFS_CMD_SET_SEL && sw.access != SW_CMD_SET) begin
				case (sw.access)
					SW_SET_BITS: s_d.cmd_set = s_q.cmd_set | sw.value;
					SW_CLR_BITS: s_d.cmd_set = s_q.cmd_set & ~sw.value;
					SW_WRITE:    s_d.cmd_set = sw.value;
					default:     s_d.cmd_set = s_q.cmd_set;
				endcase
			end else if (sw.access == SW_CMD_SET) begin
				s_d.cmd_set = sw.value;
			end else begin
				s_d.error = 1'b1;
			end
		end
		if (rd.valid) begin
			s_d.rdata.valid = 1'b1;
			s_d.rdata.data  = image_byte(rd.index, s_q.cmd_set);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '{cmd_set: RST_CMD_SET_SEL, done: 1'b0, error: 1'b0,
				rdata: '{valid: 1'b0, data: VAL_RESERVED}};
		end else begin
			s_q <= s_d;
		end
	end

	assign sw_done        = s_q.done;
	assign sw_error       = s_q.error;
	assign rdata          = s_q.rdata;
	assign cmd_set_select = s_q.cmd_set;

	a_fixed_bytes: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_ERASE_UNIT |=> rdata.valid && rdata.data == 8'h00)
		else $error("erase unit byte not zero");
	a_atomic_one: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_ATOMIC_WR |=> rdata.data == 8'h01)
		else $error("atomic write count not one");
	a_protect_zero: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_PROTECT_UNIT |=> rdata.data == 8'h00)
		else $error("protect unit byte not zero");
	a_power_zero: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index >= OFS_PWR_52_LV && rd.index <= OFS_PWR_26_HV |=> rdata.data == 8'h00)
		else $error("power class byte not zero");
	a_min_rate: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index >= OFS_MIN_R_426 && rd.index <= OFS_MIN_W_852 |=> rdata.data == 8'h08)
		else $error("minimum rate byte not eight");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && ((rd.index > OFS_EXT_REV && rd.index < OFS_STRUCT_VER) || rd.index > OFS_CMD_SETS
			|| rd.index < OFS_CMD_SET_SEL) |=> rdata.data == 8'h00)
		else $error("reserved byte not zero");
	a_ro_refused: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access != SW_CMD_SET && sw.index != OFS_CMD_SET_SEL
		|=> sw_error && $stable(cmd_set_select))
		else $error("write to fixed byte not refused");
	a_switch_write: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access == SW_WRITE && sw.index == OFS_CMD_SET_SEL
		|=> sw_done && !sw_error && cmd_set_select == $past(sw.value))
		else $error("switch write not applied");
	a_read_mode: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_CMD_SET_SEL && !sw.valid |=> rdata.data == cmd_set_select)
		else $error("mode byte read mismatch");

	// Handshake pulses and reset state
	a_done_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid
		|=> sw_done)
		else $error("switch not acknowledged");

	a_done_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!sw.valid
		|=> !sw_done && !sw_error)
		else $error("switch acknowledge without request");

	a_error_done: assert property (@(posedge clock) disable iff (!rst_n)
		sw_error
		|-> sw_done)
		else $error("refusal without acknowledge");

	a_rdata_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid
		|=> rdata.valid)
		else $error("read not answered");

	a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!rd.valid
		|=> !rdata.valid && rdata.data == VAL_RESERVED)
		else $error("read data without request");

	// No disable here: this one watches the reset itself
	a_reset_clear: assert property (@(posedge clock)
		!rst_n
		|=> !sw_done && !sw_error && !rdata.valid && cmd_set_select == RST_CMD_SET_SEL)
		else $error("outputs not cleared by reset");

	// Switch updates of the single stored mode byte
	a_set_bits: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access == SW_SET_BITS && sw.index == OFS_CMD_SET_SEL
		|=> cmd_set_select == ($past(cmd_set_select) | $past(sw.value)))
		else $error("set bits not applied");

	a_clr_bits: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access == SW_CLR_BITS && sw.index == OFS_CMD_SET_SEL
		|=> cmd_set_select == ($past(cmd_set_select) & ~$past(sw.value)))
		else $error("clear bits not applied");

	a_cmd_set_any: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access == SW_CMD_SET
		|=> sw_done && !sw_error && cmd_set_select == $past(sw.value))
		else $error("command set change not applied");

	a_mode_accepted: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.index == OFS_CMD_SET_SEL
		|=> sw_done && !sw_error)
		else $error("switch to mode byte refused");

	// Sampled reset in the antecedent keeps the reset edge itself out
	a_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)
		rst_n && !sw.valid
		|=> $stable(cmd_set_select))
		else $error("mode byte changed without switch");

	a_props_refused: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access != SW_CMD_SET && sw.index >= OFS_EXT_REV
		|=> sw_error && $stable(cmd_set_select))
		else $error("properties byte accepted a switch");

	a_modes_refused: assert property (@(posedge clock) disable iff (!rst_n)
		sw.valid && sw.access != SW_CMD_SET && sw.index < OFS_CMD_SET_SEL
		|=> sw_error && $stable(cmd_set_select))
		else $error("unimplemented mode byte accepted a switch");

	a_read_old: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_CMD_SET_SEL
		|=> rdata.valid && rdata.data == $past(cmd_set_select))
		else $error("mode byte read not the held value");

	// Fixed properties bytes, build-time figures included
	a_ext_rev: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_EXT_REV
		|=> rdata.data == VAL_EXT_REV)
		else $error("revision byte wrong");

	a_struct_ver: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_STRUCT_VER
		|=> rdata.data == VAL_STRUCT_VER)
		else $error("structure version byte wrong");

	a_speed_types: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SPEED_TYPES
		|=> rdata.data == VAL_SPEED_TYPES)
		else $error("speed types byte wrong");

	a_erase_factor: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_ERASE_FACTOR
		|=> rdata.data == VAL_ERASE_FACTOR)
		else $error("erase time factor byte wrong");

	a_access_gran: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_ACCESS_GRAN
		|=> rdata.data == VAL_ACCESS_GRAN)
		else $error("access granularity byte wrong");

	a_boot_capability_info: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_BOOT_CAPABILITY_INFO
		|=> rdata.data == VAL_BOOT_CAPABILITY_INFO)
		else $error("boot capability byte wrong");

	a_cmd_sets: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_CMD_SETS
		|=> rdata.data == VAL_CMD_SETS)
		else $error("supported command sets byte wrong");

	a_boot_size: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_BOOT_SIZE
		|=> rdata.data == BOOT_SIZE_MULT)
		else $error("boot area size byte wrong");

	a_sleep_time: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SLEEP_TIME
		|=> rdata.data == SLEEP_TIME)
		else $error("sleep time byte wrong");

	a_sleep_io: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SLEEP_IO_I
		|=> rdata.data == SLEEP_IO_I)
		else $error("sleep io current byte wrong");

	a_sleep_core: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SLEEP_CORE_I
		|=> rdata.data == SLEEP_CORE_I)
		else $error("sleep core current byte wrong");

	a_sector_low: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SECTORS_LO
		|=> rdata.data == SECTOR_COUNT[7:0])
		else $error("sector count low byte wrong");

	a_sector_high: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index == OFS_SECTORS_HI
		|=> rdata.data == SECTOR_COUNT[31:24])
		else $error("sector count high byte wrong");

	// Reserved gaps between defined properties bytes
	a_type_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_SPEED_TYPES && rd.index < OFS_PWR_52_LV
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved byte before power classes not zero");

	a_pwr_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_PWR_26_HV && rd.index < OFS_MIN_R_426
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved byte before rate bytes not zero");

	a_rate_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_MIN_W_852 && rd.index < OFS_SECTORS_LO
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved byte before sector count not zero");

	a_sector_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_SECTORS_HI && rd.index < OFS_SLEEP_TIME
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved byte after sector count not zero");

	a_boot_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_BOOT_SIZE && rd.index < OFS_BOOT_CAPABILITY_INFO
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved byte between boot bytes not zero");

	a_cmd_gap: assert property (@(posedge clock) disable iff (!rst_n)
		rd.valid && rd.index > OFS_BOOT_CAPABILITY_INFO && rd.index < OFS_CMD_SETS
		|=> rdata.data == VAL_RESERVED)
		else $error("reserved upper byte not zero");
endmodule

// ===== sim/ecp_host_model.sv
// Host controller model issuing Switch and byte-read commands
`timescale 1ns/1ns
module ecp_host_model
	import ecp_pkg::*;
(
	input  wire logic        clock,
	output      ecp_switch_t sw,
	output      ecp_read_t   rd,
	input  wire ecp_rdata_t  rdata,
	input  wire logic        sw_done,
	input  wire logic        sw_error
);
	initial begin
		sw = '0;
		rd = '0;
	end
	// Apart from reset, modes only ever change through this Switch path
	task automatic xfer(input ecp_switch_t s, input ecp_read_t r, output ecp_rdata_t got,
		output logic [1:0] st);
		@(posedge clock);
		sw <= s;
		rd <= r;
		@(posedge clock);
		sw <= '0;
		rd <= '0;
		#1;
		got = rdata;
		st = {sw_done, sw_error};
	endtask
endmodule

// ===== sim/extended_card_properties_regs_tb.sv
// Testbench for the extended card properties register image
`timescale 1ns/1ns
module extended_card_properties_regs_tb;
	import ecp_pkg::*;
	typedef struct packed {logic [8:0] idx; logic [7:0] val;} ecp_row_t;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	ecp_switch_t sw;
	ecp_read_t   rd;
	ecp_rdata_t  rdata;
	logic        sw_done;
	logic        sw_error;
	logic [7:0]  cmd_set_select;
	int          err_total = 0;
	int          tests_run = 0;
	int          cycles = 0;
	ecp_rdata_t  got;
	logic [1:0]  st;
	ecp_row_t    rows [36] = '{'{OFS_EXT_REV, 8'h02}, '{OFS_STRUCT_VER, 8'h02}, '{OFS_SPEED_TYPES, 8'h03},
		'{OFS_PWR_52_LV, 8'h00}, '{OFS_PWR_26_LV, 8'h00}, '{OFS_PWR_52_HV, 8'h00}, '{OFS_PWR_26_HV, 8'h00},
		'{OFS_MIN_R_426, 8'h08}, '{OFS_MIN_W_426, 8'h08}, '{OFS_MIN_R_826, 8'h08}, '{OFS_MIN_W_826, 8'h08},
		'{OFS_MIN_R_852, 8'h08}, '{OFS_MIN_W_852, 8'h08}, '{OFS_PROTECT_UNIT, 8'h00}, '{OFS_ATOMIC_WR, 8'h01},
		'{OFS_ERASE_UNIT, 8'h00}, '{OFS_BOOT_CAPABILITY_INFO, 8'h01}, '{OFS_CMD_SETS, 8'h00}, '{9'h1ff, 8'h00},
		'{9'h0c1, 8'h00}, '{9'h0d3, 8'h00}, '{9'h0be, 8'h00}, '{OFS_ACCESS_GRAN, 8'h00},
		'{OFS_ERASE_FACTOR, 8'h00}, '{OFS_BOOT_SIZE, 8'h02}, '{OFS_SLEEP_TIME, 8'h21},
		'{OFS_SLEEP_IO_I, 8'h32}, '{OFS_SLEEP_CORE_I, 8'h43}, '{OFS_SECTORS_LO, 8'h44},
		'{9'h0d5, 8'h33}, '{OFS_SECTORS_HI, 8'h11}, '{9'h1f0, 8'h00}, '{9'h0d8, 8'h00},
		'{9'h0cc, 8'h00}, '{9'h0c6, 8'h00}, '{9'h0e3, 8'h00}};
	always #5 clock = ~clock;
	// Distinct build-time figures so that byte order and wiring show up
	ecp_regs #(.SECTOR_COUNT(32'h11223344), .SLEEP_TIME(8'h21), .SLEEP_IO_I(8'h32), .SLEEP_CORE_I(8'h43))
		u_ecp_regs (.clock(clock), .rst_n(rst_n), .sw(sw), .sw_done(sw_done), .sw_error(sw_error),
		.rd(rd), .rdata(rdata), .cmd_set_select(cmd_set_select));
	ecp_host_model u_ecp_host_model (.clock(clock), .sw(sw), .rd(rd), .rdata(rdata), .sw_done(sw_done),
		.sw_error(sw_error));
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdb(input logic [8:0] idx, input logic [7:0] exp);
		u_ecp_host_model.xfer('0, '{1'b1, idx}, got, st);
		chk(got, {1'b1, exp});
	endtask
	task automatic swb(input ecp_access_t a, input logic [8:0] idx, input logic [7:0] v, input logic e);
		u_ecp_host_model.xfer('{1'b1, a, idx, v}, '0, got, st);
		chk({7'h0, st}, {7'h0, 1'b1, e});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Ceiling well above the roughly 125 cycles the sequence needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk({1'b0, cmd_set_select}, 9'h000);
		foreach (rows[i]) rdb(rows[i].idx, rows[i].val);
		swb(SW_WRITE, OFS_CMD_SET_SEL, 8'h5a, 1'b0);
		rdb(OFS_CMD_SET_SEL, 8'h5a);
		swb(SW_SET_BITS, OFS_CMD_SET_SEL, 8'h81, 1'b0);
		chk({1'b0, cmd_set_select}, 9'h0db);
		swb(SW_CLR_BITS, OFS_CMD_SET_SEL, 8'h0f, 1'b0);
		chk({1'b0, cmd_set_select}, 9'h0d0);
		swb(SW_CMD_SET, 9'h1ff, 8'h03, 1'b0);
		for (int a = 1; a < 4; a++) begin
			swb(ecp_access_t'(a), OFS_ERASE_UNIT, 8'hff, 1'b1);
			swb(ecp_access_t'(a), OFS_ATOMIC_WR, 8'h00, 1'b1);
			swb(ecp_access_t'(a), 9'h0d3, 8'hff, 1'b1);
			swb(ecp_access_t'(a), 9'h0be, 8'hff, 1'b1);
		end
		rdb(OFS_ERASE_UNIT, 8'h00);
		rdb(OFS_ATOMIC_WR, 8'h01);
		rdb(9'h0d3, 8'h00);
		rdb(9'h0be, 8'h00);
		chk({1'b0, cmd_set_select}, 9'h003);
		u_ecp_host_model.xfer('{1'b1, SW_WRITE, OFS_CMD_SET_SEL, 8'h77}, '{1'b1, OFS_CMD_SET_SEL}, got, st);
		chk(got, 9'h103);
		chk({1'b0, cmd_set_select}, 9'h077);
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk({1'b0, cmd_set_select}, 9'h000);
		rdb(OFS_MIN_W_852, 8'h08);
		tally_and_finish();
	end
endmodule
